// ### src/ata_host_pkg.sv
// Purpose: Shared constants for the native-mode host port controller.
// Assumes: 40 MHz clock; the device answers on a plain parallel port.
// Notes: Command and status registers of the controller are local choices.
package ata_host_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_NS = 25;
   localparam int STROBE_NS = 250;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_NS = 25;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STRAP_HOLD_MS = 1;
   localparam int STRAP_HOLD_CYC = STRAP_HOLD_MS * 1000000 / CLK_NS;
   // ----------------------------------------
   // Controller registers
   // ----------------------------------------
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_WDATA = 4'h1;
   localparam logic [3:0] REG_RDATA = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_CONFIG = 4'h4;
   localparam logic [3:0] REG_SPEED = 4'h5;
   localparam logic [3:0] REG_IOADDR = 4'h6;
   // Command and status word fields.
   localparam int CMD_WRITE_BIT = 0;
   localparam int CMD_KIND_LSB = 1;
   localparam int CMD_REG_LSB = 4;
   localparam int CMD_BYTE_BIT = 7;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_MODE_BIT = 1;
   localparam int STAT_ERR_BIT = 2;
   localparam int STAT_WIDE_BIT = 3;
   // Access kinds.
   localparam logic [2:0] KIND_TASK = 3'h0;
   localparam logic [2:0] KIND_CTRL = 3'h1;
   localparam logic [2:0] KIND_DMA = 3'h2;
   localparam logic [2:0] KIND_SOCKET = 3'h3;
   // ----------------------------------------
   // Native and socket map addresses
   // ----------------------------------------
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_ERR_FEAT = 3'h1;
   localparam logic [2:0] ADDR_ALT_STATUS = 3'h6;
   localparam logic [2:0] ADDR_DRIVE_ADDR = 3'h7;
   localparam logic [10:0] MEM_REG_LO = 11'h000;
   localparam logic [10:0] MEM_REG_HI = 11'h00f;
   localparam logic [10:0] MEM_WIN_LO = 11'h400;
   localparam logic [10:0] PRI_TASK_BASE = 11'h1f0;
   localparam logic [10:0] PRI_CTRL_BASE = 11'h3f0;
   localparam logic [10:0] SEC_TASK_BASE = 11'h170;
   localparam logic [10:0] SEC_CTRL_BASE = 11'h370;
   localparam logic [3:0] CTRL_OFFSET = 4'h6;
   localparam logic [1:0] CFG_MEMORY = 2'h0;
   localparam logic [1:0] CFG_CONTIG = 2'h1;
   localparam logic [1:0] CFG_PRIMARY = 2'h2;
   localparam logic [1:0] CFG_SECONDARY = 2'h3;
   localparam logic [3:0] PRIMARY_IRQ = 4'he;
   // ----------------------------------------
   // Speed tuple codes
   // ----------------------------------------
   localparam logic [3:0] TUPLE_FUNC_SPEC = 4'hd;
   localparam int TUPLE_NOWP_BIT = 3;
   localparam int TUPLE_EXT_BIT = 7;
   localparam logic [7:0] SPEED_250 = 8'hd9;
   localparam logic [7:0] SPEED_100 = 8'hdc;
   localparam logic [7:0] SPEED_EXT = 8'hdf;
   localparam logic [7:0] SPEED_EXT_120 = 8'h12;
   localparam logic [7:0] SPEED_EXT_80 = 8'h79;
endpackage

// ### src/strap_sync.sv
// Purpose: Two-stage synchroniser for one pin.
// Assumes: Input is asynchronous to clk.
// Notes: The first stage feeds only the second.
`timescale 1ns/100ps
module strap_sync
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pinIn,
   output logic pinOut
);
   logic stage1;
   logic next_stage1;
   logic next_pinOut;

   always_comb
   begin
      next_stage1 = pinIn;
      next_pinOut = stage1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage1 <= 1'b1;
         pinOut <= 1'b1;
      end
      else
      begin
         stage1 <= next_stage1;
         pinOut <= next_pinOut;
      end
   end
endmodule

// ### src/speed_tuple_check.sv
// Purpose: Decodes speed tuple bytes read from attribute memory.
// Assumes: Bytes arrive from registers on the same clock.
// Notes: Result is registered.
`timescale 1ns/100ps
module speed_tuple_check
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] firstByte,
   input wire logic [7:0] extByte,
   output logic [2:0] speedCode,
   output logic tupleOk
);
   import ata_host_pkg::*;
   logic [2:0] next_speedCode;
   logic next_tupleOk;

   always_comb
   begin
      next_speedCode = 3'h0;
      next_tupleOk = (firstByte[7:4] == TUPLE_FUNC_SPEC)
         && firstByte[TUPLE_NOWP_BIT];
      if (firstByte == SPEED_250)
      begin
         next_speedCode = 3'h1;
      end
      else if (firstByte == SPEED_100)
      begin
         next_speedCode = 3'h2;
      end
      else if (firstByte == SPEED_EXT && !extByte[TUPLE_EXT_BIT])
      begin
         if (extByte == SPEED_EXT_120)
         begin
            next_speedCode = 3'h3;
         end
         else if (extByte == SPEED_EXT_80)
         begin
            next_speedCode = 3'h4;
         end
      end
      if (next_speedCode == 3'h0)
      begin
         next_tupleOk = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         speedCode <= 3'h0;
         tupleOk <= 1'b0;
      end
      else
      begin
         speedCode <= next_speedCode;
         tupleOk <= next_tupleOk;
      end
   end
endmodule

// ### src/ata_host_port.sv
// Purpose: Host controller driving a flash card's native or socket port.
// Assumes: Software issues one access at a time through the command port.
// Notes: Strobe width and setup are fixed counts of the 40 MHz clock.
//
// What this block does
// - Native mode once strap held low STRAP_HOLD cycles.
// - Task file 1-7h bytes, address 0 word.
// - DMA ack moves words; control 6h/7h; invalids.
// - Byte pair on even enable: even first.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
module ata_host_port
#(
   parameter int STRAP_HOLD = ata_host_pkg::STRAP_HOLD_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdata,
   output logic nativeModeStrap_n,
   output logic taskFileSelect_n,
   output logic controlBlockSelect_n,
   output logic dmaAcknowledge_n,
   output logic ioReadStrobe_n,
   output logic ioWriteStrobe_n,
   output logic evenByteEnable_n,
   output logic oddByteEnable_n,
   output logic attrSelect_n,
   output logic [10:0] devAddr,
   output logic [15:0] dataOut,
   output logic [15:0] dataOe,
   input wire logic [15:0] dataIn,
   input wire logic widePortIndicate_n
);
   import ata_host_pkg::*;

   typedef enum {IDLE, SETUP, STROBE, HOLD} state_e;

   // ----------------------------------------
   // Address mapping
   // ----------------------------------------
   function automatic logic [10:0] mapAddr(input logic [1:0] cfg,
                                           input logic ctrl,
                                           input logic [3:0] off,
                                           input logic [10:0] base);
      logic [10:0] a;
      a = 11'h000;
      case (cfg)
         CFG_MEMORY: a = MEM_REG_LO | {7'h00, off};
         CFG_CONTIG: a = {base[10:4], off};
         CFG_PRIMARY: a = (ctrl ? PRI_CTRL_BASE : PRI_TASK_BASE)
            | {7'h00, off};
         CFG_SECONDARY: a = (ctrl ? SEC_CTRL_BASE : SEC_TASK_BASE)
            | {7'h00, off};
         default: a = 11'h000;
      endcase
      return a;
   endfunction

   logic strapSync;
   logic nativeMode;
   logic next_nativeMode;
   logic strapDrive;
   logic next_strapDrive;
   logic [1:0] cfgIndex;
   logic [1:0] next_cfgIndex;
   logic [10:0] ioBase;
   logic [10:0] next_ioBase;
   logic [15:0] wdata;
   logic [15:0] next_wdata;
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   logic [15:0] speedBytes;
   logic [15:0] next_speedBytes;
   logic [7:0] cmd;
   logic [7:0] next_cmd;
   logic errFlag;
   logic next_errFlag;
   logic wideSeen;
   logic next_wideSeen;
   logic oddPhase;
   logic next_oddPhase;
   logic [31:0] strapCnt;
   logic [31:0] next_strapCnt;
   logic [15:0] regRdataNext;
   state_e state;
   state_e next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [2:0] speedCode;
   logic tupleOk;
   logic wideSync;

   strap_sync u_strap
   (
      .clk(clk),
      .rst(rst),
      .pinIn(nativeModeStrap_n),
      .pinOut(strapSync)
   );

   strap_sync u_wide
   (
      .clk(clk),
      .rst(rst),
      .pinIn(widePortIndicate_n),
      .pinOut(wideSync)
   );

   speed_tuple_check u_speed
   (
      .clk(clk),
      .rst(rst),
      .firstByte(speedBytes[7:0]),
      .extByte(speedBytes[15:8]),
      .speedCode(speedCode),
      .tupleOk(tupleOk)
   );

   // ----------------------------------------
   // Command decode and access sequencing
   // ----------------------------------------
   logic [2:0] kind;
   logic [2:0] regSel;
   logic isWrite;
   logic byteMode;
   logic invalidReq;

   always_comb
   begin
      kind = cmd[CMD_KIND_LSB +: 3];
      regSel = cmd[CMD_REG_LSB +: 3];
      isWrite = cmd[CMD_WRITE_BIT];
      byteMode = cmd[CMD_BYTE_BIT];
      invalidReq = (kind == KIND_SOCKET) == nativeMode
         || (kind == KIND_CTRL && regSel != ADDR_ALT_STATUS
             && regSel != ADDR_DRIVE_ADDR)
         || (kind == KIND_CTRL && regSel == ADDR_DRIVE_ADDR && isWrite)
         || (kind == KIND_DMA && !nativeMode);
   end

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_cmd = cmd;
      next_wdata = wdata;
      next_rdata = rdata;
      next_errFlag = errFlag;
      next_wideSeen = wideSeen;
      next_oddPhase = oddPhase;
      next_cfgIndex = cfgIndex;
      next_ioBase = ioBase;
      next_speedBytes = speedBytes;
      if (regWrite && state == IDLE)
      begin
         case (regAddr)
            REG_CMD:
            begin
               next_cmd = regWdata[7:0];
               next_state = SETUP;
               next_cnt = 8'(SETUP_CYC);
               next_errFlag = 1'b0;
               next_oddPhase = 1'b0;
            end
            REG_WDATA: next_wdata = regWdata;
            REG_CONFIG: next_cfgIndex = regWdata[1:0];
            REG_SPEED: next_speedBytes = regWdata;
            REG_IOADDR: next_ioBase = regWdata[10:0];
            default: next_wdata = wdata;
         endcase
      end
      case (state)
         IDLE: next_cnt = (next_state == SETUP) ? 8'(SETUP_CYC) : 8'h00;
         SETUP:
         begin
            if (invalidReq)
            begin
               next_errFlag = 1'b1;
               next_state = IDLE;
            end
            else if (cnt <= 8'h01)
            begin
               next_state = STROBE;
               next_cnt = 8'(STROBE_CYC);
            end
            else
            begin
               next_cnt = cnt - 8'h01;
            end
         end
         STROBE:
         begin
            if (cnt <= 8'h01)
            begin
               next_state = HOLD;
               next_wideSeen = !wideSync;
               if (!isWrite)
               begin
                  if (byteMode && oddPhase)
                  begin
                     next_rdata[15:8] = dataIn[7:0];
                  end
                  else if (byteMode)
                  begin
                     next_rdata = {8'h00, oddByteEnable_n ? dataIn[7:0]
                        : dataIn[15:8]};
                  end
                  else
                  begin
                     next_rdata = dataIn;
                  end
               end
            end
            else
            begin
               next_cnt = cnt - 8'h01;
            end
         end
         HOLD:
         begin
            if (byteMode && regSel == ADDR_DATA && kind != KIND_CTRL
                && !oddPhase && kind != KIND_DMA)
            begin
               next_oddPhase = 1'b1;
               next_state = SETUP;
               next_cnt = 8'(SETUP_CYC);
            end
            else
            begin
               next_state = IDLE;
            end
         end
         default: next_state = IDLE;
      endcase
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   logic active;
   logic strobing;

   always_comb
   begin
      active = state != IDLE && !invalidReq;
      strobing = state == STROBE;
      taskFileSelect_n = 1'b1;
      controlBlockSelect_n = 1'b1;
      dmaAcknowledge_n = 1'b1;
      evenByteEnable_n = 1'b1;
      oddByteEnable_n = 1'b1;
      attrSelect_n = 1'b1;
      devAddr = 11'h000;
      dataOut = 16'h0000;
      dataOe = 16'h0000;
      if (active && nativeMode)
      begin
         case (kind)
            KIND_TASK:
            begin
               taskFileSelect_n = 1'b0;
               devAddr = {8'h00, regSel};
            end
            KIND_CTRL:
            begin
               controlBlockSelect_n = 1'b0;
               devAddr = {8'h00, regSel};
            end
            default: dmaAcknowledge_n = 1'b0;
         endcase
      end
      else if (active)
      begin
         attrSelect_n = cfgIndex == CFG_MEMORY;
         devAddr = mapAddr(cfgIndex, regSel == ADDR_ALT_STATUS
            && kind == KIND_CTRL, {kind == KIND_CTRL, regSel}, ioBase);
         if (!byteMode)
         begin
            evenByteEnable_n = 1'b0;
            oddByteEnable_n = 1'b0;
         end
         else if (regSel == ADDR_ERR_FEAT && !oddPhase)
         begin
            oddByteEnable_n = 1'b0;
            devAddr[2:0] = ADDR_DATA;
         end
         else
         begin
            evenByteEnable_n = 1'b0;
         end
      end
      if (active && isWrite)
      begin
         dataOe = byteMode ? 16'h00ff : 16'hffff;
         dataOut = oddPhase ? {8'h00, wdata[15:8]} : wdata;
         if (byteMode && !oddByteEnable_n)
         begin
            dataOe = 16'hff00;
            dataOut = {wdata[7:0], 8'h00};
         end
      end
   end

   assign ioReadStrobe_n = !(strobing && active && !isWrite);
   assign ioWriteStrobe_n = !(strobing && active && isWrite);
   assign nativeModeStrap_n = !strapDrive;

   // ----------------------------------------
   // Mode tracking
   // ----------------------------------------
   always_comb
   begin
      next_strapDrive = strapDrive;
      next_nativeMode = nativeMode;
      next_strapCnt = strapCnt;
      if (regWrite && regAddr == REG_CONFIG && state == IDLE)
      begin
         next_strapDrive = regWdata[8];
         next_strapCnt = 32'h0;
      end
      if (strapSync)
      begin
         next_nativeMode = 1'b0;
         next_strapCnt = 32'h0;
      end
      else if (strapCnt >= 32'(STRAP_HOLD))
      begin
         next_nativeMode = 1'b1;
      end
      else
      begin
         next_strapCnt = strapCnt + 32'h1;
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   always_comb
   begin
      regRdataNext = 16'h0000;
      case (regAddr)
         REG_CMD: regRdataNext = {8'h00, cmd};
         REG_WDATA: regRdataNext = wdata;
         REG_RDATA: regRdataNext = rdata;
         REG_STATUS: regRdataNext = {8'h00, tupleOk, speedCode, wideSeen,
            errFlag, nativeMode, state != IDLE};
         REG_CONFIG: regRdataNext = {7'h00, strapDrive, 4'h0, PRIMARY_IRQ
            [1:0], cfgIndex};
         REG_SPEED: regRdataNext = speedBytes;
         REG_IOADDR: regRdataNext = {5'h00, ioBase};
         default: regRdataNext = 16'h0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= IDLE;
         cnt <= 8'h00;
         cmd <= 8'h00;
         wdata <= 16'h0000;
         rdata <= 16'h0000;
         errFlag <= 1'b0;
         wideSeen <= 1'b0;
         oddPhase <= 1'b0;
         cfgIndex <= CFG_PRIMARY;
         ioBase <= 11'h000;
         speedBytes <= 16'h0000;
         strapDrive <= 1'b0;
         nativeMode <= 1'b0;
         strapCnt <= 32'h0;
         regRdata <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         cmd <= next_cmd;
         wdata <= next_wdata;
         rdata <= next_rdata;
         errFlag <= next_errFlag;
         wideSeen <= next_wideSeen;
         oddPhase <= next_oddPhase;
         cfgIndex <= next_cfgIndex;
         ioBase <= next_ioBase;
         speedBytes <= next_speedBytes;
         strapDrive <= next_strapDrive;
         nativeMode <= next_nativeMode;
         strapCnt <= next_strapCnt;
         regRdata <= regRead ? regRdataNext : 16'h0000;
      end
   end
endmodule

// ### verif/ata_host_port_monitor.sv
// Purpose: Port checker for the host port controller.
// Assumes: Bound to ata_host_port; one clock domain.
// Notes: Watches only the device-side outputs.
`timescale 1ns/100ps
module ata_host_port_monitor
(
   input wire logic clk,
   input wire logic rst,
   input wire logic taskFileSelect_n,
   input wire logic controlBlockSelect_n,
   input wire logic dmaAcknowledge_n,
   input wire logic ioReadStrobe_n,
   input wire logic ioWriteStrobe_n,
   input wire logic evenByteEnable_n,
   input wire logic oddByteEnable_n,
   input wire logic attrSelect_n,
   input wire logic [10:0] devAddr,
   input wire logic [15:0] dataOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic idle;
   assign idle = taskFileSelect_n & controlBlockSelect_n & dmaAcknowledge_n;
   // ----------------------------------------
   // Strobe sequences
   // ----------------------------------------
   sequence s_rd_ten;
      (!ioReadStrobe_n)[*5] ##1 (!ioReadStrobe_n)[*5] ##1 ioReadStrobe_n;
   endsequence
   sequence s_wr_ten;
      (!ioWriteStrobe_n)[*5] ##1 (!ioWriteStrobe_n)[*5] ##1 ioWriteStrobe_n;
   endsequence
   property p_reset;
      $fell(rst) |-> idle && ioReadStrobe_n && ioWriteStrobe_n
         && dataOe == 16'h0000;
   endproperty
   property p_one_strobe;
      !(!ioReadStrobe_n && !ioWriteStrobe_n);
   endproperty
   property p_no_both_sel;
      !(!taskFileSelect_n && !controlBlockSelect_n);
   endproperty
   property p_dma_alone;
      !dmaAcknowledge_n |-> taskFileSelect_n && controlBlockSelect_n;
   endproperty
   property p_rd_width;
      $fell(ioReadStrobe_n) |-> s_rd_ten;
   endproperty
   property p_wr_width;
      $fell(ioWriteStrobe_n) |-> s_wr_ten;
   endproperty
   property p_rd_release;
      !ioReadStrobe_n |-> dataOe == 16'h0000;
   endproperty
   property p_wr_drive;
      !ioWriteStrobe_n && !(evenByteEnable_n && !oddByteEnable_n)
         |-> dataOe[7:0] == 8'hff;
   endproperty
   property p_word;
      !ioWriteStrobe_n && !evenByteEnable_n && !oddByteEnable_n
         |-> dataOe == 16'hffff;
   endproperty
   property p_setup;
      $fell(ioReadStrobe_n) || $fell(ioWriteStrobe_n) |-> $stable({idle,
         taskFileSelect_n, evenByteEnable_n, oddByteEnable_n, devAddr});
   endproperty
   property p_end;
      $rose(ioReadStrobe_n) || $rose(ioWriteStrobe_n) |-> ##[0:2] idle;
   endproperty
   property p_native_pins;
      !idle |-> evenByteEnable_n && oddByteEnable_n && attrSelect_n;
   endproperty
   a_reset: assert property (p_reset) else $error("bus busy after reset");
   a_one_strobe: assert property (p_one_strobe) else $error("two strobes");
   a_no_both_sel: assert property (p_no_both_sel) else $error("two selects");
   a_dma_alone: assert property (p_dma_alone) else $error("ack with select");
   a_rd_width: assert property (p_rd_width) else $error("read width");
   a_wr_width: assert property (p_wr_width) else $error("write width");
   a_rd_release: assert property (p_rd_release) else $error("read driven");
   a_wr_drive: assert property (p_wr_drive) else $error("write lane");
   a_word: assert property (p_word) else $error("word lanes");
   a_setup: assert property (p_setup) else $error("select setup");
   a_end: assert property (p_end) else $error("select held");
   a_native_pins: assert property (p_native_pins) else $error("enables");
endmodule
bind ata_host_port ata_host_port_monitor u_ata_host_port_monitor (.*);

// ### verif/ata_card_model.sv
// Purpose: Behavioural card answering native and socket accesses.
// Assumes: Pins come from the host controller on the same clock.
// Notes: A released bus shows a pattern that flips every cycle.
`timescale 1ns/100ps
module ata_card_model
#(
   parameter logic [7:0] DRIVE_ADDR = 8'h3c
)
(
   input wire logic clk,
   input wire logic nativeModeStrap_n,
   input wire logic taskFileSelect_n,
   input wire logic controlBlockSelect_n,
   input wire logic dmaAcknowledge_n,
   input wire logic ioReadStrobe_n,
   input wire logic ioWriteStrobe_n,
   input wire logic evenByteEnable_n,
   input wire logic oddByteEnable_n,
   input wire logic attrSelect_n,
   input wire logic [10:0] devAddr,
   input wire logic [15:0] dataOut,
   output logic [15:0] dataIn,
   output logic widePortIndicate_n
);
   logic [7:0] tf [0:7];
   logic [15:0] word, rdVal, last;
   logic native, hit, taskHit, ctrlHit, dHit, strobe, prevStrobe, bp, rdEn;
   logic [2:0] idx;
   logic [1:0] en;
   initial
   begin
      bp = 1'b0;
      last = 16'h0000;
      prevStrobe = 1'b0;
   end
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign native = !nativeModeStrap_n;
   assign idx = devAddr[2:0];
   assign en = {oddByteEnable_n, evenByteEnable_n};
   assign strobe = !ioReadStrobe_n || !ioWriteStrobe_n;
   assign hit = !native && !attrSelect_n && !devAddr[10]
      && (devAddr[8:3] == 6'h3e || devAddr[8:3] == 6'h2e)
      && (!devAddr[9] || idx[2:1] == 2'b11);
   assign taskHit = (native && !taskFileSelect_n) || (hit && !devAddr[9]);
   assign ctrlHit = (native && !controlBlockSelect_n) || (hit && devAddr[9]);
   assign dHit = (taskHit && idx == 3'h0) || (native && !dmaAcknowledge_n);
   assign rdEn = !ioReadStrobe_n && (taskHit || ctrlHit || dHit);
   assign widePortIndicate_n = !(hit && strobe);
   assign dataIn = rdEn ? rdVal : ~last;
   always_comb
   begin
      rdVal = {~last[15:8], tf[idx]};
      if (ctrlHit)
         rdVal[7:0] = (idx == 3'h7) ? DRIVE_ADDR : tf[7];
      else if (dHit && (native || en == 2'b00))
         rdVal = word;
      else if (dHit && en == 2'b10)
         rdVal[7:0] = bp ? word[15:8] : word[7:0];
      else if (dHit)
         rdVal[15:8] = tf[1];
   end
   always @(posedge clk)
   begin
      last <= dataIn;
      prevStrobe <= strobe;
      if (prevStrobe && !strobe && dHit && !native && en == 2'b10)
         bp <= !bp;
      if (!ioWriteStrobe_n && dHit && (native || en == 2'b00))
         word <= dataOut;
      else if (!ioWriteStrobe_n && dHit && en == 2'b10 && bp)
         word[15:8] <= dataOut[7:0];
      else if (!ioWriteStrobe_n && dHit && en == 2'b10)
         word[7:0] <= dataOut[7:0];
      else if (!ioWriteStrobe_n && dHit)
         tf[1] <= dataOut[15:8];
      else if (!ioWriteStrobe_n && taskHit)
         tf[idx] <= dataOut[7:0];
   end
endmodule

// ### verif/ata_host_port_mode_and_decode_tb.sv
// Purpose: Self-checking bench for the host port controller.
// Assumes: Card model on the far side; short strap hold.
// Notes: Reads queue their expectation; a watcher compares.
`timescale 1ns/100ps
module ata_host_port_mode_and_decode_tb;
   import ata_host_pkg::*;
   logic clk, rst, regWrite, regRead, rdPrev, nativeModeStrap_n;
   logic taskFileSelect_n, controlBlockSelect_n, dmaAcknowledge_n;
   logic ioReadStrobe_n, ioWriteStrobe_n, evenByteEnable_n;
   logic oddByteEnable_n, attrSelect_n, widePortIndicate_n;
   logic [3:0] regAddr;
   logic [10:0] devAddr;
   logic [15:0] regWdata, regRdata, dataOut, dataOe, dataIn, w;
   logic [15:0] expQ [$], maskQ [$];
   logic [31:0] seed;
   logic [7:0] tv [0:7];
   logic [23:0] spd [0:6] = '{24'h9000d9, 24'ha000dc, 24'hb012df,
      24'hc079df, 24'h0000d1, 24'h0092df, 24'h000059};
   int num_errors, num_checks;
   ata_host_port #(.STRAP_HOLD(8)) u_ata_host_port (.*);
   ata_card_model u_ata_card_model (.*);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   task automatic final_report();
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] seen, e, m);
      num_checks++;
      if ((seen & m) !== (e & m))
      begin
         num_errors++;
         $display("Error regRdata expected %h seen %h", e & m, seen & m);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
      @(posedge clk);
      expQ.push_back(e);
      maskQ.push_back(m);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
   endtask
   task automatic acc(input logic wb, input logic [2:0] k, r, input logic b);
      wr(REG_CMD, {8'h00, b, r, k, wb});
      rd(REG_STATUS, 16'h0001, 16'h0001);
      repeat (32) @(posedge clk);
   endtask
   task automatic tw(input logic [2:0] k, r, input logic b, logic [15:0] d);
      wr(REG_WDATA, d);
      acc(1'b1, k, r, b);
   endtask
   task automatic tr(input logic [2:0] k, r, input logic b, logic [15:0] e, m);
      acc(1'b0, k, r, b);
      rd(REG_RDATA, e, m);
   endtask
   always @(posedge clk)
   begin
      rdPrev <= regRead;
      if (rdPrev === 1'b1)
         cmp(regRdata, expQ.pop_front(), maskQ.pop_front());
   end
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #1000000;
      num_errors++;
      final_report();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      regAddr = 4'h0;
      regWdata = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      rdPrev = 1'b0;
      rst = 1'b1;
      seed = 32'ha6230fe1;
      num_errors = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(REG_STATUS, 16'h0000, 16'h0007);
      rd(REG_CONFIG, 16'h0002, 16'h0103);
      rd(4'hf, 16'h0000, 16'hffff);
      for (int c = 2; c < 4; c++)
      begin
         wr(REG_CONFIG, 16'(c));
         w = rnd();
         tw(KIND_SOCKET, 3'h0, 1'b1, w);
         tr(KIND_SOCKET, 3'h0, 1'b0, w, 16'hffff);
         w = rnd();
         tw(KIND_SOCKET, 3'h0, 1'b0, w);
         tr(KIND_SOCKET, 3'h0, 1'b1, w, 16'hffff);
         tw(KIND_SOCKET, 3'h3, 1'b1, ~w);
         tr(KIND_SOCKET, 3'h3, 1'b1, ~w, 16'h00ff);
         tw(KIND_SOCKET, ADDR_ERR_FEAT, 1'b1, w);
         tr(KIND_SOCKET, ADDR_ERR_FEAT, 1'b1, w, 16'h00ff);
      end
      wr(REG_CONFIG, 16'h0102);
      repeat (20) @(posedge clk);
      rd(REG_STATUS, 16'h000a, 16'h000e);
      for (int r = 1; r < 8; r++)
      begin
         w = rnd();
         tv[r] = w[7:0];
         tw(KIND_TASK, 3'(r), 1'b0, w);
      end
      for (int r = 1; r < 8; r++)
         tr(KIND_TASK, 3'(r), 1'b0, {8'h00, tv[r]}, 16'h00ff);
      w = rnd();
      tw(KIND_TASK, ADDR_DATA, 1'b0, w);
      tr(KIND_DMA, 3'h0, 1'b0, w, 16'hffff);
      tw(KIND_DMA, 3'h0, 1'b0, ~w);
      tr(KIND_TASK, ADDR_DATA, 1'b0, ~w, 16'hffff);
      tw(KIND_CTRL, ADDR_ALT_STATUS, 1'b0, 16'h0002);
      tr(KIND_CTRL, ADDR_ALT_STATUS, 1'b0, {8'h00, tv[7]}, 16'h00ff);
      tr(KIND_CTRL, ADDR_DRIVE_ADDR, 1'b0, 16'h003c, 16'h00ff);
      wr(REG_CMD, {8'h00, 1'b0, 3'h0, KIND_SOCKET, 1'b1});
      repeat (4) @(posedge clk);
      rd(REG_STATUS, 16'h0004, 16'h000d);
      wr(REG_CONFIG, 16'h0002);
      repeat (6) @(posedge clk);
      rd(REG_STATUS, 16'h0000, 16'h0002);
      for (int i = 0; i < 7; i++)
      begin
         wr(REG_SPEED, spd[i][15:0]);
         repeat (4) @(posedge clk);
         rd(REG_STATUS, 16'(spd[i][23:16]), 16'h00f0);
      end
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(REG_CONFIG, 16'h0002, 16'h0103);
      repeat (4) @(posedge clk);
      final_report();
   end
endmodule
